// ### hw/spi_core_params.svh
// constants for the serial peripheral core: widths, depths, timing counts
// assumes it is included by the package and the design file by bare name
`ifndef SPI_CORE_PARAMS_SVH
`define SPI_CORE_PARAMS_SVH
`define DATA_W 8
`define FIFO_DEPTH 32
`define BIT_CNT_W 5
`define EDGES_PER_BYTE 5'h10
`define SCK_HALF_W 4
`define SCK_HALF_CYCLES 4'h4
`define SYNC_W 4
`define SYNC_SS 0
`define SYNC_SCK 1
`define SYNC_MOSI 2
`define SYNC_MISO 3
`define DATA_RESET 8'h00
// synchroniser idles at the line levels: clock low, select and data high
`define SYNC_RESET 4'hd
`define FLAGS_RESET 3'h1
`endif

// ### hw/spi_core_pkg.sv
// types shared by the serial peripheral core
// assumes spi_core_params.svh is on the include path
`include "spi_core_params.svh"
package spi_core_pkg;
    typedef struct packed {
        logic system_enable;
        logic master_select;
        logic fault_detect_enable;
        logic select_output_enable;
        logic bidir_select;
        logic bidir_output_enable;
        logic stop_in_wait;
    } ctrl_s;
    typedef struct packed {
        logic mode_fault_flag;
        logic transfer_complete_flag;
        logic transmit_empty_flag;
    } status_s;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_TRAIL = 2'b11
    } master_state_e;
endpackage

// ### hw/spi_core.sv
// serial peripheral core: pins, mode fault, low power, flags, transmit fifo
// assumes single clock clk_in; all pins arrive asynchronous and are synchronised
`timescale 1ns/1ns
`default_nettype none
`include "spi_core_params.svh"

module spi_tx_fifo #(
    parameter int WIDTH = `DATA_W,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic push;
    logic pop;
    assign out_valid_out = wr_ptr_reg != rd_ptr_reg;
    assign in_ready_out = (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]) || !out_valid_out;
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end
endmodule

module spi_core (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire spi_core_pkg::ctrl_s ctrl_in,
    input wire logic ctrl_write_in,
    input wire logic status_read_in,
    input wire logic data_read_in,
    input wire logic wait_mode_in,
    input wire logic stop_mode_in,
    input wire logic [`DATA_W-1:0] tx_data_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    output logic [`DATA_W-1:0] serial_data_register_out,
    output spi_core_pkg::status_s status_out,
    output logic master_select_out,
    output logic irq_out,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_out,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe_out,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe_out,
    input wire logic ss_n_in,
    output logic ss_n_out,
    output logic ss_n_oe_out
);
    import spi_core_pkg::*;

    ctrl_s ctrl_reg;
    status_s flags_reg;
    master_state_e mstate_reg;
    logic [`SYNC_W-1:0] sync1_reg;
    logic [`SYNC_W-1:0] sync2_reg;
    logic [`DATA_W-1:0] shreg_reg;
    logic [`BIT_CNT_W-1:0] edge_cnt_reg;
    logic [`SCK_HALF_W-1:0] half_cnt_reg;
    logic [`DATA_W-1:0] data_reg;
    logic [`DATA_W-1:0] deferred_data_reg;
    logic [`DATA_W-1:0] hold_byte_reg;
    logic sck_prev_reg, ss_prev_reg, sample_reg, sck_reg, clear_arm_reg, fifo_valid_prev_reg;
    logic lp_prev_reg, entry_busy_reg, deferred_reg, from_fifo_reg;

    logic [`DATA_W-1:0] fifo_data;
    logic [`DATA_W-1:0] copy_data;
    logic fifo_valid, fifo_pop, enabled, is_master, auto_ss, fault_event, master_freeze;
    logic slave_lp, half_tick, master_start, master_done, slave_active, slave_start;
    logic slave_rise, slave_fall, slave_done, slave_busy, din, copy_now;

    spi_tx_fifo #(.WIDTH(`DATA_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .in_data_in(tx_data_in),
        .in_valid_in(tx_valid_in),
        .in_ready_out(tx_ready_out),
        .out_data_out(fifo_data),
        .out_valid_out(fifo_valid),
        .out_ready_in(fifo_pop)
    );

    // pins are asynchronous; only the second stage is looked at
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1_reg <= `SYNC_RESET;
            sync2_reg <= `SYNC_RESET;
        end else begin
            sync1_reg <= {miso_in, mosi_in, sck_in, ss_n_in};
            sync2_reg <= sync1_reg;
        end
    end

    assign enabled = ctrl_reg.system_enable;
    assign is_master = ctrl_reg.master_select;
    assign auto_ss = is_master && ctrl_reg.select_output_enable
        && ctrl_reg.fault_detect_enable && !ctrl_reg.bidir_select;
    // select input watched for a mode fault only by a master with detection on and no auto output
    assign fault_event = enabled && is_master && ctrl_reg.fault_detect_enable
        && !auto_ss && !sync2_reg[`SYNC_SS];
    assign master_freeze = stop_mode_in || (wait_mode_in && ctrl_reg.stop_in_wait);
    assign slave_lp = !is_master && master_freeze;
    // shared pin always feeds the shift input in bidirectional mode
    assign din = ctrl_reg.bidir_select
        ? (is_master ? sync2_reg[`SYNC_MOSI] : sync2_reg[`SYNC_MISO])
        : (is_master ? sync2_reg[`SYNC_MISO] : sync2_reg[`SYNC_MOSI]);

    // control bits; a fault overrides the master and shared pin enables
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl_reg <= '0;
        end else if (fault_event) begin
            ctrl_reg.master_select <= 1'b0;
            if (ctrl_reg.bidir_select) ctrl_reg.bidir_output_enable <= 1'b0;
        end else if (ctrl_write_in) begin
            ctrl_reg <= ctrl_in;
        end
    end

    // master engine: mode 0, msb first, fixed divider
    assign half_tick = half_cnt_reg == `SCK_HALF_CYCLES;
    assign master_start = enabled && is_master && !master_freeze && !fault_event
        && mstate_reg == ST_IDLE && fifo_valid;
    assign master_done = mstate_reg == ST_TRAIL && half_tick && !master_freeze;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mstate_reg <= ST_IDLE;
            half_cnt_reg <= '0;
            sck_reg <= 1'b0;
        end else if (fault_event || !enabled || !is_master) begin
            mstate_reg <= ST_IDLE;
            half_cnt_reg <= '0;
            sck_reg <= 1'b0;
        end else if (!master_freeze) begin
            unique case (mstate_reg)
                ST_IDLE: begin
                    half_cnt_reg <= '0;
                    if (master_start) mstate_reg <= ST_SHIFT;
                end
                ST_SHIFT: begin
                    half_cnt_reg <= half_tick ? '0 : half_cnt_reg + 1'b1;
                    if (half_tick) begin
                        sck_reg <= !sck_reg;
                        if (sck_reg && edge_cnt_reg == `EDGES_PER_BYTE - 5'h1) begin
                            mstate_reg <= ST_TRAIL;
                        end
                    end
                end
                ST_TRAIL: begin
                    half_cnt_reg <= half_tick ? '0 : half_cnt_reg + 1'b1;
                    if (half_tick) mstate_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // slave engine follows the synchronised clock while selected
    assign slave_active = enabled && !is_master && !flags_reg.mode_fault_flag
        && !sync2_reg[`SYNC_SS];
    assign slave_start = slave_active && ss_prev_reg;
    assign slave_rise = slave_active && sync2_reg[`SYNC_SCK] && !sck_prev_reg;
    assign slave_fall = slave_active && !sync2_reg[`SYNC_SCK] && sck_prev_reg;
    assign slave_done = slave_fall && edge_cnt_reg == `EDGES_PER_BYTE - 5'h1;
    assign slave_busy = slave_active && edge_cnt_reg != '0;
    assign fifo_pop = master_start || (slave_start && !slave_lp && fifo_valid);

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sck_prev_reg <= 1'b0;
            ss_prev_reg <= 1'b1;
        end else begin
            sck_prev_reg <= sync2_reg[`SYNC_SCK];
            ss_prev_reg <= sync2_reg[`SYNC_SS];
        end
    end

    // shared shift register and edge counter for both roles
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            shreg_reg <= '0;
            sample_reg <= 1'b0;
            edge_cnt_reg <= '0;
            from_fifo_reg <= 1'b0;
            hold_byte_reg <= '0;
        end else if (fault_event) begin
            edge_cnt_reg <= '0;
        end else if (master_start) begin
            shreg_reg <= fifo_data;
            edge_cnt_reg <= '0;
        end else if (is_master) begin
            if (mstate_reg == ST_SHIFT && half_tick && !master_freeze) begin
                edge_cnt_reg <= edge_cnt_reg + 5'h1;
                if (!sck_reg) sample_reg <= din;
                else shreg_reg <= {shreg_reg[`DATA_W-2:0], sample_reg};
            end
        end else if (!slave_active) begin
            edge_cnt_reg <= '0;
        end else if (slave_start) begin
            edge_cnt_reg <= '0;
            if (!slave_lp) begin
                from_fifo_reg <= fifo_valid;
                if (fifo_valid) begin
                    shreg_reg <= fifo_data;
                    hold_byte_reg <= fifo_data;
                end
            end else if (from_fifo_reg) begin
                shreg_reg <= hold_byte_reg;
            end
        end else if (slave_rise) begin
            sample_reg <= din;
            edge_cnt_reg <= edge_cnt_reg + 5'h1;
        end else if (slave_fall) begin
            shreg_reg <= {shreg_reg[`DATA_W-2:0], sample_reg};
            edge_cnt_reg <= slave_done ? '0 : edge_cnt_reg + 5'h1;
        end
    end

    // slave low power: completion of a byte already in progress at entry held back and released on exit
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lp_prev_reg <= 1'b0;
            entry_busy_reg <= 1'b0;
            deferred_reg <= 1'b0;
            deferred_data_reg <= '0;
        end else begin
            lp_prev_reg <= slave_lp;
            if (slave_lp && !lp_prev_reg) begin
                entry_busy_reg <= slave_busy;
                deferred_reg <= 1'b0;
            end else if (slave_lp && slave_done && entry_busy_reg) begin
                deferred_reg <= 1'b1;
                deferred_data_reg <= {shreg_reg[`DATA_W-2:0], sample_reg};
                entry_busy_reg <= 1'b0;
            end else if (!slave_lp && lp_prev_reg) begin
                deferred_reg <= 1'b0;
            end
        end
    end

    assign copy_now = master_done || (slave_done && !slave_lp)
        || (!slave_lp && lp_prev_reg && deferred_reg);
    assign copy_data = (slave_done || master_done)
        ? {shreg_reg[`DATA_W-2:0], master_done ? shreg_reg[0] : sample_reg}
        : deferred_data_reg;

    // master shifted its last bit already; a slave still merges the sample
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            data_reg <= `DATA_RESET;
        end else if (copy_now) begin
            data_reg <= (master_done && !slave_done) ? shreg_reg : copy_data;
        end
    end

    // flags: hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flags_reg <= `FLAGS_RESET;
            clear_arm_reg <= 1'b0;
            fifo_valid_prev_reg <= 1'b0;
        end else begin
            fifo_valid_prev_reg <= fifo_valid;
            if (status_read_in) clear_arm_reg <= 1'b1;
            else if (ctrl_write_in || data_read_in || (tx_valid_in && tx_ready_out)) begin
                clear_arm_reg <= 1'b0;
            end
            if (fault_event) flags_reg.mode_fault_flag <= 1'b1;
            else if (clear_arm_reg && ctrl_write_in) flags_reg.mode_fault_flag <= 1'b0;
            if (copy_now) flags_reg.transfer_complete_flag <= 1'b1;
            else if (clear_arm_reg && data_read_in) flags_reg.transfer_complete_flag <= 1'b0;
            if (fifo_valid_prev_reg && !fifo_valid) flags_reg.transmit_empty_flag <= 1'b1;
            else if (clear_arm_reg && tx_valid_in && tx_ready_out) begin
                flags_reg.transmit_empty_flag <= 1'b0;
            end
        end
    end

    assign status_out = flags_reg;
    assign serial_data_register_out = data_reg;
    assign master_select_out = ctrl_reg.master_select;
    assign irq_out = enabled && (flags_reg.mode_fault_flag
        || flags_reg.transfer_complete_flag || flags_reg.transmit_empty_flag);

    // pins: fault forces slave with the output buffer off
    assign sck_oe_out = enabled && is_master;
    assign sck_out = sck_reg;
    assign mosi_out = shreg_reg[`DATA_W-1];
    assign miso_out = shreg_reg[`DATA_W-1];
    assign mosi_oe_out = enabled && is_master
        && (!ctrl_reg.bidir_select || ctrl_reg.bidir_output_enable);
    assign miso_oe_out = slave_active
        && (!ctrl_reg.bidir_select || ctrl_reg.bidir_output_enable);
    assign ss_n_oe_out = enabled && auto_ss;
    assign ss_n_out = mstate_reg == ST_IDLE;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    sequence s_fault_read;
        status_read_in && flags_reg.mode_fault_flag;
    endsequence
    sequence s_ctrl_write_quiet;
        ctrl_write_in && !fault_event && !status_read_in && !data_read_in && !tx_valid_in;
    endsequence

    a_irq_gate: assert property (irq_out |-> enabled)
        else $error("irq without enable");
    a_fault_master_off: assert property (fault_event |=> !is_master && !sck_oe_out
        && !mosi_oe_out) else $error("fault left master drive on");
    a_fault_auto_off: assert property (auto_ss |-> !fault_event)
        else $error("fault detected with auto select");
    a_slave_no_fault: assert property (!is_master && !$past(is_master)
        |=> !$rose(flags_reg.mode_fault_flag)) else $error("fault raised in slave");
    a_no_detect_clear: assert property (is_master && !ctrl_reg.fault_detect_enable
        && !flags_reg.mode_fault_flag |=> !flags_reg.mode_fault_flag)
        else $error("fault flag set with detection off");
    a_auto_ss_frame: assert property (ss_n_oe_out && master_start |=> !ss_n_out)
        else $error("select high during transfer");
    a_idle_ss_high: assert property (master_done |=> ss_n_out)
        else $error("select low after transfer");
    a_bidir_one_pin: assert property (ctrl_reg.bidir_select && is_master
        |-> !miso_oe_out) else $error("unused pin driven");
    a_freeze_hold: assert property (master_freeze && is_master && !fault_event
        && mstate_reg == ST_SHIFT |=> $stable(edge_cnt_reg) && $stable(sck_reg))
        else $error("master not frozen");
    a_fault_clear_seq: assert property (s_fault_read ##1 s_ctrl_write_quiet
        |=> !flags_reg.mode_fault_flag) else $error("fault flag not cleared");
    a_copy_sets_flag: assert property (copy_now |=> flags_reg.transfer_complete_flag)
        else $error("copy without completion flag");
    a_lp_no_copy: assert property (slave_lp && lp_prev_reg |-> !copy_now)
        else $error("copy during low power");
endmodule
`default_nettype wire

// ### dv/spi_slave_model.sv
// external serial slave facing the core's master side: mode 0, msb first
// assumes select low frames each byte and the clock idles low between frames
`timescale 1ns/1ns
`default_nettype none
module spi_slave_model (
    input wire logic sck_in,
    input wire logic ss_n_in,
    input wire logic mosi_in,
    input wire logic [7:0] reply_in,
    output logic miso_out,
    output logic [7:0] rx_out
);
    logic [7:0] sh;
    logic smp;
    logic ss_seen;
    initial begin
        sh = '0;
        smp = 1'b0;
        ss_seen = 1'b1;
        miso_out = 1'b0;
        rx_out = '0;
    end
    always @(posedge sck_in) if (!ss_n_in) smp = mosi_in;
    // one process owns the line: select edges load or release, clock falls shift
    always @(ss_n_in or negedge sck_in) begin
        if (ss_n_in !== ss_seen) begin
            ss_seen = ss_n_in;
            if (ss_n_in) begin
                // released line shows the inverse so a stale bit never passes for data
                miso_out = ~miso_out;
            end else begin
                // fresh reply per frame, first bit valid before the first rising edge
                sh = reply_in;
                miso_out = reply_in[7];
            end
        end else if (!ss_n_in) begin
            sh = {sh[6:0], smp};
            miso_out = sh[7];
            rx_out = sh;
        end
    end
endmodule
`default_nettype wire

// ### dv/spi_special_modes_faults_power_tb.sv
// bench for spi_core: control rows, master and slave transfers, fault, low power
// assumes spi_core_pkg and spi_slave_model are compiled before this file
`timescale 1ns/1ns
`default_nettype none
module spi_special_modes_faults_power_tb;
    import spi_core_pkg::*;
    logic clk_in, nrst_in, ctrl_write_in, status_read_in, data_read_in, moved, s;
    logic wait_mode_in, stop_mode_in, tx_valid_in, tb_sck, tb_mosi, tb_ss;
    ctrl_s ctrl_in;
    status_s status_out;
    logic [7:0] tx_data_in, reply, rx, got, serial_data_register_out;
    logic tx_ready_out, master_select_out, irq_out, sck_out, sck_oe_out, mosi_out;
    logic mosi_oe_out, miso_out, miso_oe_out, ss_n_out, ss_n_oe_out, slave_miso;
    logic sck_w, mosi_w, miso_w, ss_w;
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;
    typedef struct packed {logic [6:0] c; logic ss; logic [5:0] e;} row_s;
    // expected: sck_oe, mosi_oe, miso_oe, ss_n_oe, irq, mode fault
    row_s rows[10] = '{{7'h60, 1'b1, 6'h32}, {7'h78, 1'b1, 6'h36},
        {7'h70, 1'b1, 6'h32}, {7'h66, 1'b1, 6'h32}, {7'h64, 1'b1, 6'h22},
        {7'h68, 1'b0, 6'h32}, {7'h40, 1'b0, 6'h0a}, {7'h56, 1'b0, 6'h0a},
        {7'h40, 1'b1, 6'h02}, {7'h20, 1'b1, 6'h00}};
    assign sck_w = sck_oe_out ? sck_out : tb_sck;
    assign mosi_w = mosi_oe_out ? mosi_out : tb_mosi;
    assign miso_w = miso_oe_out ? miso_out : slave_miso;
    assign ss_w = ss_n_oe_out ? ss_n_out : tb_ss;
    spi_core DUT (.clk_in(clk_in), .nrst_in(nrst_in), .ctrl_in(ctrl_in),
        .ctrl_write_in(ctrl_write_in), .status_read_in(status_read_in),
        .data_read_in(data_read_in), .wait_mode_in(wait_mode_in),
        .stop_mode_in(stop_mode_in), .tx_data_in(tx_data_in), .tx_valid_in(tx_valid_in),
        .tx_ready_out(tx_ready_out), .serial_data_register_out(serial_data_register_out),
        .status_out(status_out), .master_select_out(master_select_out), .irq_out(irq_out),
        .sck_in(sck_w), .sck_out(sck_out), .sck_oe_out(sck_oe_out), .mosi_in(mosi_w),
        .mosi_out(mosi_out), .mosi_oe_out(mosi_oe_out), .miso_in(miso_w),
        .miso_out(miso_out), .miso_oe_out(miso_oe_out), .ss_n_in(ss_w),
        .ss_n_out(ss_n_out), .ss_n_oe_out(ss_n_oe_out));
    spi_slave_model partner (.sck_in(sck_w), .ss_n_in(ss_w), .mosi_in(mosi_w),
        .reply_in(reply), .miso_out(slave_miso), .rx_out(rx));
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // a hang counts as a failure and still reaches the verdict
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 6000) begin
            n_fail++;
            end_sim();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #10;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic note(input string t);
        $display("test %s done: %0d comparisons, %0d mismatches", t, n_tests, n_fail);
    endtask
    task automatic wctrl(input logic [6:0] c);
        ctrl_in = c;
        ctrl_write_in = 1'b1;
        tick(1);
        ctrl_write_in = 1'b0;
    endtask
    task automatic push(input logic [7:0] d);
        tx_data_in = d;
        tx_valid_in = 1'b1;
        tick(1);
        tx_valid_in = 1'b0;
    endtask
    task automatic sread;
        status_read_in = 1'b1;
        tick(1);
        status_read_in = 1'b0;
    endtask
    task automatic dread;
        data_read_in = 1'b1;
        tick(1);
        data_read_in = 1'b0;
    endtask
    task automatic wait_flag(input int b, input int lim);
        int i;
        i = 0;
        while (status_out[b] !== 1'b1 && i < lim) begin
            tick(1);
            i++;
        end
        chk(status_out[b], 1'b1);
    endtask
    task automatic reset_dut;
        nrst_in = 1'b0;
        tick(4);
        nrst_in = 1'b1;
        tick(1);
        chk({tx_ready_out, sck_oe_out, mosi_oe_out, miso_oe_out, ss_n_oe_out, ss_n_out,
            irq_out}, 8'h42);
        chk(serial_data_register_out, 8'h00);
        chk(status_out, 3'b001);
    endtask
    // the bench acts as external master; the link clock stands still outside frames
    task automatic xfer(input logic [7:0] d, input int lp_at);
        tb_ss = 1'b0;
        tick(8);
        for (int i = 0; i < 8; i++) begin
            tb_mosi = d[7-i];
            tick(4);
            got = {got[6:0], miso_w};
            tb_sck = 1'b1;
            if (i == lp_at) wait_mode_in = 1'b1;
            tick(4);
            tb_sck = 1'b0;
        end
        tick(8);
        tb_ss = 1'b1;
        tb_mosi = ~tb_mosi;
        tick(8);
    endtask
    initial begin
        {ctrl_write_in, status_read_in, data_read_in, wait_mode_in} = 4'h0;
        {stop_mode_in, tx_valid_in, tb_sck, tb_mosi, tb_ss} = 5'h01;
        {nrst_in, ctrl_in, tx_data_in, got, reply, moved, s} = '0;
        reset_dut();
        note("reset");
        foreach (rows[i]) begin
            tb_ss = rows[i].ss;
            wctrl(rows[i].c);
            tick(6);
            chk({sck_oe_out, mosi_oe_out, miso_oe_out, ss_n_oe_out, irq_out,
                status_out.mode_fault_flag}, rows[i].e);
        end
        note("control rows");
        tb_ss = 1'b1;
        reply = 8'ha5;
        wctrl(7'h78);
        push(8'h3c);
        tick(40);
        chk(ss_n_out, 1'b0);
        wait_flag(1, 300);
        chk(rx, 8'h3c);
        chk(serial_data_register_out, 8'ha5);
        chk({ss_n_out, status_out}, 4'hb);
        dread();
        chk(status_out.transfer_complete_flag, 1'b1);
        sread();
        dread();
        chk(status_out.transfer_complete_flag, 1'b0);
        note("auto select");
        wctrl(7'h76);
        push(8'hc3);
        tick(30);
        tb_ss = 1'b0;
        wait_flag(2, 10);
        chk({master_select_out, sck_oe_out, mosi_oe_out, miso_oe_out, irq_out}, 8'h01);
        tb_ss = 1'b1;
        tick(100);
        chk(status_out.transfer_complete_flag, 1'b0);
        chk(serial_data_register_out, 8'ha5);
        wctrl(7'h40);
        chk(status_out.mode_fault_flag, 1'b1);
        sread();
        wctrl(7'h40);
        chk({status_out.mode_fault_flag, irq_out}, 8'h01);
        wctrl(7'h60);
        tick(150);
        sread();
        dread();
        note("mode fault");
        reply = 8'h7e;
        for (int k = 0; k < 3; k++) begin
            wctrl({6'h3c, k == 1});
            push({6'h20, k[1:0]});
            tick(30);
            stop_mode_in = (k == 0);
            wait_mode_in = (k > 0);
            tick(3);
            s = sck_out;
            moved = 1'b0;
            repeat (50) begin
                tick(1);
                moved = moved | (sck_out !== s);
            end
            chk(moved, k == 2);
            {stop_mode_in, wait_mode_in} = 2'b00;
            wait_flag(1, 300);
            chk(rx, {6'h20, k[1:0]});
            chk(serial_data_register_out, 8'h7e);
            sread();
            dread();
        end
        note("freeze");
        wctrl(7'h41);
        push(8'h5a);
        xfer(8'h96, 3);
        chk(got, 8'h5a);
        chk(status_out.transfer_complete_flag, 1'b0);
        wait_mode_in = 1'b0;
        tick(5);
        chk(status_out.transfer_complete_flag, 1'b1);
        chk(serial_data_register_out, 8'h96);
        sread();
        dread();
        wait_mode_in = 1'b1;
        tick(10);
        wait_mode_in = 1'b0;
        tick(10);
        chk(status_out.transfer_complete_flag, 1'b0);
        note("slave low power");
        reset_dut();
        note("second reset");
        end_sim();
    end
endmodule
`default_nettype wire
